//--- adc_ctrl_pkg.sv
// Constants, register map and types of the converter control block.
// Assumes byte-indexed registers placed one per 32-bit word on the bus.
package adc_ctrl_pkg;
  // ==========================================
  // Register indices and bus address
  localparam int ADDR_W = 12;
  localparam logic [7:0] IDX_RES_LO = 8'h78;
  localparam logic [7:0] IDX_RES_HI = 8'h79;
  localparam logic [7:0] IDX_CSR_A = 8'h7A;
  localparam logic [7:0] IDX_CSR_B = 8'h7B;
  localparam logic [7:0] IDX_SEL = 8'h7C;
  localparam logic [7:0] IDX_DIS = 8'h7E;
  // ==========================================
  // Field positions
  localparam int SEL_REF_HI = 7;
  localparam int SEL_REF_LO = 6;
  localparam int SEL_LADJ = 5;
  localparam int SEL_CH_HI = 3;
  localparam int CSRA_EN = 7;
  localparam int CSRA_SC = 6;
  localparam int CSRA_ATE = 5;
  localparam int CSRA_IF = 4;
  localparam int CSRA_IE = 3;
  localparam int CSRA_PS_HI = 2;
  localparam int CSRB_CME = 6;
  localparam int CSRB_TS_HI = 2;
  localparam int DIS_HI = 5;
  // ==========================================
  // Reset values and timing
  localparam logic [7:0] RST_SEL = 8'h00;
  localparam logic [7:0] RST_CSRA = 8'h00;
  localparam logic [7:0] RST_CSRB = 8'h00;
  localparam logic [7:0] RST_DIS = 8'h00;
  localparam logic [9:0] RST_RES = 10'h000;
  localparam logic [4:0] CYC_FIRST = 5'h19;
  localparam logic [4:0] CYC_NORMAL = 5'h0D;
  localparam logic [2:0] TS_FREE = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================
  // Types and helpers
  typedef enum logic {ST_IDLE, ST_CONV} conv_state_t;
  function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction
  function automatic logic [6:0] prescale_mask(input logic [2:0] ps);
    case (ps)
      3'h0, 3'h1: return 7'h01;
      3'h2: return 7'h03;
      3'h3: return 7'h07;
      3'h4: return 7'h0F;
      3'h5: return 7'h1F;
      3'h6: return 7'h3F;
      default: return 7'h7F;
    endcase
  endfunction
endpackage

//--- adc_ctrl.sv
// Control and status logic of a 10-bit successive-approximation converter.
// Assumes an AXI4-Lite master on CLOCK and an analog core that converts
// on CONV_TICK strobes while CONV_BUSY is high.
`timescale 1ns/10ps
module adc_ctrl (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_B,
  // AXI4-Lite write channels
  input wire logic [adc_ctrl_pkg::ADDR_W-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // AXI4-Lite read channels
  input wire logic [adc_ctrl_pkg::ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // Analog core
  input wire logic [9:0] CORE_RESULT,
  output logic CONV_ON,
  output logic CONV_BUSY,
  output logic CONV_TICK,
  output logic [1:0] REF_SELECT,
  output logic [3:0] CHANNEL_SELECT,
  output logic COMP_MUX_EN,
  // Trigger flags, interrupt
  input wire logic [7:1] TRIG_FLAGS,
  input wire logic GLOBAL_IRQ_EN,
  input wire logic IRQ_ACK,
  output logic IRQ_REQ,
  // Digital pins
  input wire logic [5:0] PIN_RAW,
  output logic [5:0] PIN_READ,
  output logic [5:0] PIN_BUF_DISABLE
);
  // ==========================================
  // Declarations
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic [adc_ctrl_pkg::ADDR_W-1:0] awaddr_ff;
  logic [7:0] wdata_ff;
  logic wstrb_ff;
  logic [1:0] sel_ref_ff, act_ref_ff, lag_ref_ff;
  logic [3:0] sel_ch_ff, act_ch_ff, lag_ch_ff;
  logic ladj_ff, en_ff, ate_ff, ie_ff, flag_ff, cme_ff;
  logic [2:0] ps_ff, ts_ff;
  logic [5:0] dis_ff, pin_s1_ff, pin_s2_ff, pin_read_ff;
  logic [9:0] core_s1_ff, core_s2_ff, res_ff;
  logic [6:0] pre_ff;
  logic [4:0] cyc_ff;
  logic init_ff, first_ff, lock_ff, trig_prev_ff, irq_ff, busy_ff, tick_ff;
  adc_ctrl_pkg::conv_state_t state_ff, nxt_state;
  logic wr_go, wr_ok, wr_sel, wr_csra, wr_csrb, wr_dis, wr_hit;
  logic rd_go, rd_lo, rd_hi, rd_hit;
  logic [7:0] rd_byte;
  logic tick, done, restart, kill, sw_start, trig_sel, trig_edge, trig_start;
  logic [4:0] conv_len;

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_B);

  // ==========================================
  // Bus slave: write path
  function automatic logic at(input logic [adc_ctrl_pkg::ADDR_W-1:0] a,
                              input logic [7:0] idx);
    return a == adc_ctrl_pkg::byte_addr(idx);
  endfunction

  assign wr_go = !awready_ff && !wready_ff && !bvalid_ff;
  assign wr_ok = wr_go && wstrb_ff;
  assign wr_sel = wr_ok && at(awaddr_ff, adc_ctrl_pkg::IDX_SEL);
  assign wr_csra = wr_ok && at(awaddr_ff, adc_ctrl_pkg::IDX_CSR_A);
  assign wr_csrb = wr_ok && at(awaddr_ff, adc_ctrl_pkg::IDX_CSR_B);
  assign wr_dis = wr_ok && at(awaddr_ff, adc_ctrl_pkg::IDX_DIS);
  assign wr_hit = wr_sel || wr_csra || wr_csrb || wr_dis
    || at(awaddr_ff, adc_ctrl_pkg::IDX_RES_LO) || at(awaddr_ff, adc_ctrl_pkg::IDX_RES_HI);

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      awaddr_ff <= '0;
      wdata_ff <= 8'h00;
      wstrb_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= adc_ctrl_pkg::RESP_OKAY;
    end else begin
      if (AWVALID && awready_ff) begin
        awready_ff <= 1'b0;
        awaddr_ff <= AWADDR;
      end
      if (WVALID && wready_ff) begin
        wready_ff <= 1'b0;
        wdata_ff <= WDATA[7:0];
        wstrb_ff <= WSTRB[0];
      end
      if (wr_go) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_hit || !wstrb_ff ? adc_ctrl_pkg::RESP_OKAY : adc_ctrl_pkg::RESP_SLVERR;
      end else if (bvalid_ff && BREADY) begin
        bvalid_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
    end
  end

  // ==========================================
  // Bus slave: read path
  assign rd_go = ARVALID && arready_ff;
  assign rd_lo = rd_go && at(ARADDR, adc_ctrl_pkg::IDX_RES_LO);
  assign rd_hi = rd_go && at(ARADDR, adc_ctrl_pkg::IDX_RES_HI);

  always_comb begin
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    if (rd_lo) begin
      rd_byte = ladj_ff ? {res_ff[1:0], 6'h00} : res_ff[7:0];
    end else if (rd_hi) begin
      rd_byte = ladj_ff ? res_ff[9:2] : {6'h00, res_ff[9:8]};
    end else if (at(ARADDR, adc_ctrl_pkg::IDX_CSR_A)) begin
      rd_byte = {en_ff, busy_ff, ate_ff, flag_ff, ie_ff, ps_ff};
    end else if (at(ARADDR, adc_ctrl_pkg::IDX_CSR_B)) begin
      rd_byte = {1'b0, cme_ff, 3'h0, ts_ff};
    end else if (at(ARADDR, adc_ctrl_pkg::IDX_SEL)) begin
      rd_byte = {sel_ref_ff, ladj_ff, 1'b0, sel_ch_ff};
    end else if (at(ARADDR, adc_ctrl_pkg::IDX_DIS)) begin
      rd_byte = {2'h0, dis_ff};
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= adc_ctrl_pkg::RESP_OKAY;
    end else if (rd_go) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= {24'h00_0000, rd_byte};
      rresp_ff <= rd_hit ? adc_ctrl_pkg::RESP_OKAY : adc_ctrl_pkg::RESP_SLVERR;
    end else if (rvalid_ff && RREADY) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  // ==========================================
  // Control registers
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      {sel_ref_ff, ladj_ff} <= adc_ctrl_pkg::RST_SEL[7:5];
      sel_ch_ff <= adc_ctrl_pkg::RST_SEL[3:0];
      {en_ff, ate_ff} <= {adc_ctrl_pkg::RST_CSRA[7], adc_ctrl_pkg::RST_CSRA[5]};
      {ie_ff, ps_ff} <= adc_ctrl_pkg::RST_CSRA[3:0];
      cme_ff <= adc_ctrl_pkg::RST_CSRB[6];
      ts_ff <= adc_ctrl_pkg::RST_CSRB[2:0];
      dis_ff <= adc_ctrl_pkg::RST_DIS[5:0];
    end else begin
      if (wr_sel) begin
        sel_ref_ff <= wdata_ff[adc_ctrl_pkg::SEL_REF_HI:adc_ctrl_pkg::SEL_REF_LO];
        ladj_ff <= wdata_ff[adc_ctrl_pkg::SEL_LADJ];
        sel_ch_ff <= wdata_ff[adc_ctrl_pkg::SEL_CH_HI:0];
      end
      if (wr_csra) begin
        en_ff <= wdata_ff[adc_ctrl_pkg::CSRA_EN];
        ate_ff <= wdata_ff[adc_ctrl_pkg::CSRA_ATE];
        ie_ff <= wdata_ff[adc_ctrl_pkg::CSRA_IE];
        ps_ff <= wdata_ff[adc_ctrl_pkg::CSRA_PS_HI:0];
      end
      if (wr_csrb) begin
        cme_ff <= wdata_ff[adc_ctrl_pkg::CSRB_CME];
        ts_ff <= wdata_ff[adc_ctrl_pkg::CSRB_TS_HI:0];
      end
      if (wr_dis) begin
        dis_ff <= wdata_ff[adc_ctrl_pkg::DIS_HI:0];
      end
    end
  end

  // ==========================================
  // Prescaler, held at zero while disabled
  assign tick = en_ff && ((pre_ff & adc_ctrl_pkg::prescale_mask(ps_ff))
    == adc_ctrl_pkg::prescale_mask(ps_ff));

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      pre_ff <= 7'h00;
    end else if (!en_ff) begin
      pre_ff <= 7'h00;
    end else begin
      pre_ff <= pre_ff + 7'h01;
    end
  end

  // ==========================================
  // Trigger selection and edge detection
  always_comb begin
    trig_sel = 1'b0;
    if (ts_ff != adc_ctrl_pkg::TS_FREE) begin
      trig_sel = TRIG_FLAGS[ts_ff];
    end
  end

  // Previous level follows the selection, so a switch can make an edge
  assign trig_edge = trig_sel && !trig_prev_ff;
  assign trig_start = en_ff && ate_ff && trig_edge && !kill;

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      trig_prev_ff <= 1'b0;
    end else begin
      trig_prev_ff <= trig_sel;
    end
  end

  // ==========================================
  // Conversion sequencer
  assign kill = wr_csra && !wdata_ff[adc_ctrl_pkg::CSRA_EN];
  assign sw_start = wr_csra && wdata_ff[adc_ctrl_pkg::CSRA_EN] && wdata_ff[adc_ctrl_pkg::CSRA_SC];
  assign conv_len = first_ff ? adc_ctrl_pkg::CYC_FIRST : adc_ctrl_pkg::CYC_NORMAL;
  assign done = state_ff == adc_ctrl_pkg::ST_CONV && en_ff && !kill && tick
    && cyc_ff == conv_len - 5'h01;
  assign restart = done && ate_ff && ts_ff == adc_ctrl_pkg::TS_FREE;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      adc_ctrl_pkg::ST_IDLE: begin
        if (sw_start || trig_start) begin
          nxt_state = adc_ctrl_pkg::ST_CONV;
        end
      end
      adc_ctrl_pkg::ST_CONV: begin
        if (kill || !en_ff || (done && !restart)) begin
          nxt_state = adc_ctrl_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      state_ff <= adc_ctrl_pkg::ST_IDLE;
      busy_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      busy_ff <= nxt_state == adc_ctrl_pkg::ST_CONV;
    end
  end

  // Initialisation is owed again after every disable
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      cyc_ff <= 5'h00;
      init_ff <= 1'b1;
      first_ff <= 1'b0;
    end else begin
      // A start written with the enable leaves en_ff low at that edge
      if (state_ff == adc_ctrl_pkg::ST_CONV) begin
        init_ff <= 1'b0;
      end else if (!en_ff) begin
        init_ff <= 1'b1;
      end
      if (state_ff == adc_ctrl_pkg::ST_IDLE) begin
        cyc_ff <= 5'h00;
        first_ff <= init_ff;
      end else if (done) begin
        cyc_ff <= 5'h00;
        first_ff <= 1'b0;
      end else if (tick) begin
        cyc_ff <= cyc_ff + 5'h01;
      end
    end
  end

  // Selection seen by the core; free running lags one conversion
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      act_ref_ff <= adc_ctrl_pkg::RST_SEL[7:6];
      act_ch_ff <= adc_ctrl_pkg::RST_SEL[3:0];
      lag_ref_ff <= adc_ctrl_pkg::RST_SEL[7:6];
      lag_ch_ff <= adc_ctrl_pkg::RST_SEL[3:0];
    end else if (state_ff == adc_ctrl_pkg::ST_IDLE) begin
      act_ref_ff <= sel_ref_ff;
      act_ch_ff <= sel_ch_ff;
      lag_ref_ff <= sel_ref_ff;
      lag_ch_ff <= sel_ch_ff;
    end else if (done) begin
      act_ref_ff <= restart ? lag_ref_ff : sel_ref_ff;
      act_ch_ff <= restart ? lag_ch_ff : sel_ch_ff;
      lag_ref_ff <= sel_ref_ff;
      lag_ch_ff <= sel_ch_ff;
    end
  end

  // ==========================================
  // Result capture and read lock
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      core_s1_ff <= 10'h000;
      core_s2_ff <= 10'h000;
      res_ff <= adc_ctrl_pkg::RST_RES;
      lock_ff <= 1'b0;
    end else begin
      core_s1_ff <= CORE_RESULT;
      core_s2_ff <= core_s1_ff;
      if (done && !lock_ff) begin
        res_ff <= core_s2_ff;
      end
      if (rd_lo) begin
        lock_ff <= 1'b1;
      end else if (rd_hi) begin
        lock_ff <= 1'b0;
      end
    end
  end

  // ==========================================
  // Completion flag and interrupt request
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      flag_ff <= adc_ctrl_pkg::RST_CSRA[4];
      irq_ff <= 1'b0;
    end else begin
      if (done) begin
        flag_ff <= 1'b1;
      end else if (IRQ_ACK || (wr_csra && wdata_ff[adc_ctrl_pkg::CSRA_IF])) begin
        flag_ff <= 1'b0;
      end
      irq_ff <= flag_ff && ie_ff && GLOBAL_IRQ_EN;
    end
  end

  // ==========================================
  // Digital input buffers and core strobe
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      pin_s1_ff <= 6'h00;
      pin_s2_ff <= 6'h00;
      pin_read_ff <= 6'h00;
      tick_ff <= 1'b0;
    end else begin
      pin_s1_ff <= PIN_RAW;
      pin_s2_ff <= pin_s1_ff;
      pin_read_ff <= pin_s2_ff & ~dis_ff;
      tick_ff <= tick && state_ff == adc_ctrl_pkg::ST_CONV;
    end
  end

  // ==========================================
  // Outputs
  assign AWREADY = awready_ff;
  assign WREADY = wready_ff;
  assign BVALID = bvalid_ff;
  assign BRESP = bresp_ff;
  assign ARREADY = arready_ff;
  assign RVALID = rvalid_ff;
  assign RDATA = rdata_ff;
  assign RRESP = rresp_ff;
  assign CONV_ON = en_ff;
  assign CONV_BUSY = busy_ff;
  assign CONV_TICK = tick_ff;
  assign REF_SELECT = act_ref_ff;
  assign CHANNEL_SELECT = act_ch_ff;
  assign COMP_MUX_EN = cme_ff;
  assign IRQ_REQ = irq_ff;
  assign PIN_READ = pin_read_ff;
  assign PIN_BUF_DISABLE = dis_ff;

  // ==========================================
  // Checks
  property p_flag_set;
    done |=> flag_ff;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set at done");

  property p_flag_clr;
    wr_csra && wdata_ff[adc_ctrl_pkg::CSRA_IF] && !done |=> !flag_ff;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");

  property p_irq;
    flag_ff && ie_ff && GLOBAL_IRQ_EN ##1 flag_ff |-> IRQ_REQ;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt request missing");

  property p_off;
    !en_ff && !sw_start |=> !CONV_BUSY;
  endproperty
  a_off: assert property (p_off) else $error("busy while disabled");

  property p_busy_end;
    done && !restart |=> ##1 (!rd_byte[adc_ctrl_pkg::CSRA_SC]
      || !at(ARADDR, adc_ctrl_pkg::IDX_CSR_A));
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("start bit stuck");

  property p_defer;
    state_ff == adc_ctrl_pkg::ST_CONV && !done |=> $stable(CHANNEL_SELECT) && $stable(REF_SELECT);
  endproperty
  a_defer: assert property (p_defer) else $error("selection changed mid conversion");

  property p_lock;
    lock_ff && done |=> $stable(res_ff);
  endproperty
  a_lock: assert property (p_lock) else $error("result changed while locked");

  property p_free_no_trig;
    ts_ff == adc_ctrl_pkg::TS_FREE |-> !trig_start;
  endproperty
  a_free_no_trig: assert property (p_free_no_trig) else $error("free running triggered");

  property p_tick_gap;
    tick |=> !tick;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("prescaler below two");

  property p_pin_dis;
    (dis_ff[0] ##1 dis_ff[0]) |=> !PIN_READ[0];
  endproperty
  a_pin_dis: assert property (p_pin_dis) else $error("disabled pin reads one");
endmodule

//--- adc_core_model.sv
// Behavioural stand-in for the analog converter core and input mux.
// Assumes the control block drives busy, tick and selections on CLOCK.
`timescale 1ns/10ps
module adc_core_model (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_B,
  // Converter control
  input wire logic CONV_BUSY,
  input wire logic CONV_TICK,
  input wire logic [1:0] REF_SELECT,
  input wire logic [3:0] CHANNEL_SELECT,
  // Result and observation
  output logic [9:0] CORE_RESULT,
  output int tick_total,
  output int tick_gap
);
  int since;

  // ==========================================
  // Sample value
  // Idle shows the inverse, so a stale capture cannot match by luck
  assign CORE_RESULT = CONV_BUSY ? {REF_SELECT, CHANNEL_SELECT, 4'h6} :
                       ~{REF_SELECT, CHANNEL_SELECT, 4'h6};

  // ==========================================
  // Tick counting
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      tick_total <= 0;
      tick_gap <= 0;
      since <= 0;
    end else if (CONV_TICK) begin
      tick_total <= tick_total + 1;
      tick_gap <= since + 1;
      since <= 0;
    end else begin
      since <= since + 1;
    end
  end
endmodule

//--- tb.sv
// Self-checking bench: AXI4-Lite register tasks and conversion sequences.
// Assumes the control block and the core model on one 200 MHz clock.
`timescale 1ns/10ps
module tb;
  logic CLOCK = 1'b0;
  logic RST_B = 1'b0;
  logic [11:0] AWADDR = 12'h000, ARADDR = 12'h000;
  logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
  logic [31:0] WDATA = 32'h0, RDATA;
  logic [3:0] WSTRB = 4'hF;
  logic [7:1] TRIG_FLAGS = 7'h00;
  logic GLOBAL_IRQ_EN = 1'b0, IRQ_ACK = 1'b0;
  logic [5:0] PIN_RAW = 6'h3F;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, CONV_ON, CONV_BUSY, CONV_TICK;
  logic COMP_MUX_EN, IRQ_REQ;
  logic [1:0] BRESP, RRESP, REF_SELECT;
  logic [3:0] CHANNEL_SELECT;
  logic [9:0] CORE_RESULT, res;
  logic [5:0] PIN_READ, PIN_BUF_DISABLE;
  logic [1:0] resp;
  logic [31:0] rd;
  int tick_total, tick_gap, t0;
  int error_cnt = 0, checks = 0;

  adc_ctrl uut (
    .CLOCK(CLOCK), .RST_B(RST_B), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
    .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
    .CORE_RESULT(CORE_RESULT), .CONV_ON(CONV_ON), .CONV_BUSY(CONV_BUSY),
    .CONV_TICK(CONV_TICK), .REF_SELECT(REF_SELECT), .CHANNEL_SELECT(CHANNEL_SELECT),
    .COMP_MUX_EN(COMP_MUX_EN), .TRIG_FLAGS(TRIG_FLAGS), .GLOBAL_IRQ_EN(GLOBAL_IRQ_EN),
    .IRQ_ACK(IRQ_ACK), .IRQ_REQ(IRQ_REQ), .PIN_RAW(PIN_RAW), .PIN_READ(PIN_READ),
    .PIN_BUF_DISABLE(PIN_BUF_DISABLE)
  );

  adc_core_model core (
    .CLOCK(CLOCK), .RST_B(RST_B), .CONV_BUSY(CONV_BUSY), .CONV_TICK(CONV_TICK),
    .REF_SELECT(REF_SELECT), .CHANNEL_SELECT(CHANNEL_SELECT), .CORE_RESULT(CORE_RESULT),
    .tick_total(tick_total), .tick_gap(tick_gap)
  );

  always #2.5 CLOCK = ~CLOCK;

  // ==========================================
  // Checking and closing
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ==========================================
  // Register bus
  task automatic bus_wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] s,
                        output logic [1:0] r);
    int k;
    k = 0;
    @(posedge CLOCK);
    AWADDR <= {2'h0, idx, 2'h0};
    WDATA <= {24'h0, d};
    WSTRB <= s;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do begin
      @(posedge CLOCK);
      k++;
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
    end while (BVALID !== 1'b1 && k < 100);
    r = BRESP;
    BREADY <= 1'b0;
    check("write answer", BVALID, 32'h1);
  endtask

  task automatic bus_rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
    int k;
    k = 0;
    @(posedge CLOCK);
    ARADDR <= {2'h0, idx, 2'h0};
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do begin
      @(posedge CLOCK);
      k++;
      if (ARREADY) ARVALID <= 1'b0;
    end while (RVALID !== 1'b1 && k < 100);
    d = RDATA;
    r = RRESP;
    RREADY <= 1'b0;
    check("read answer", RVALID, 32'h1);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [1:0] r;
    bus_wr(idx, d, 4'hF, r);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    bus_rd(idx, d, r);
    check(what, d, {24'h0, exp});
  endtask

  // Bounded wait for the busy level
  task automatic wait_busy(input logic want);
    int k;
    k = 0;
    while (CONV_BUSY !== want && k < 4000) begin
      @(posedge CLOCK);
      k++;
    end
    check("busy level", CONV_BUSY, want);
  endtask

  task automatic stay_idle(input int cyc);
    logic bad;
    bad = 1'b0;
    repeat (cyc) begin
      @(posedge CLOCK);
      if (CONV_BUSY !== 1'b0) bad = 1'b1;
    end
    check("spurious start", bad, 32'h0);
  endtask

  // Bounded wait for a completion request; skips the edge of a flag clear
  task automatic wait_irq;
    int k;
    k = 0;
    @(posedge CLOCK);
    while (IRQ_REQ !== 1'b1 && k < 4000) begin
      @(posedge CLOCK);
      k++;
    end
    check("irq level", IRQ_REQ, 32'h1);
  endtask

  // ==========================================
  // Sequences
  initial begin
    repeat (2) @(posedge CLOCK);
    RST_B <= 1'b1;
    bus_wr(8'h78, 8'hFF, 4'hF, resp);
    check("ignored write", resp, 32'h0);
    bus_wr(8'h7C, 8'hFF, 4'hE, resp);
    check("no strobe write", resp, 32'h0);
    bus_wr(8'h7F, 8'h00, 4'hF, resp);
    check("unmapped write", resp, 32'h2);
    for (int i = 0; i < 6; i++) begin
      rd_chk("reset value", 8'h78 + 8'(i + (i / 5)), 8'h00);
    end
    bus_rd(8'h7F, rd, resp);
    check("unmapped data", rd, 32'h0);
    check("unmapped resp", resp, 32'h2);
    for (int i = 0; i < 16; i++) begin
      wr(8'h7C, {i[1:0], 2'h1, i[3:0]});
      // Selection lands on the edge the write task returns at
      @(negedge CLOCK);
      check("reference", REF_SELECT, i[1:0]);
      check("channel", CHANNEL_SELECT, i[3:0]);
      rd_chk("select", 8'h7C, {i[1:0], 2'h0, i[3:0]});
    end
    wr(8'h7B, 8'h47);
    rd_chk("control b", 8'h7B, 8'h47);
    check("mux enable", COMP_MUX_EN, 32'h1);
    wr(8'h7B, 8'h00);
    wr(8'h7E, 8'h15);
    repeat (4) @(posedge CLOCK);
    check("pin read", {PIN_BUF_DISABLE, PIN_READ}, {6'h15, 6'h2A});
    rd_chk("pin disable", 8'h7E, 8'h15);
    // First conversion, deferred selection, result layout and lock
    wr(8'h7C, 8'h43);
    t0 = tick_total;
    wr(8'h7A, 8'hC2);
    rd_chk("start bit", 8'h7A, 8'hC2);
    wr(8'h7C, 8'h45);
    check("channel held", CHANNEL_SELECT, 32'h3);
    wait_busy(1'b0);
    repeat (2) @(posedge CLOCK);
    check("first ticks", tick_total - t0, 32'd25);
    check("tick gap", tick_gap, 32'd4);
    check("channel applied", CHANNEL_SELECT, 32'h5);
    rd_chk("done flag", 8'h7A, 8'h92);
    res = {2'h1, 4'h3, 4'h6};
    rd_chk("low right", 8'h78, res[7:0]);
    t0 = tick_total;
    wr(8'h7A, 8'hC2);
    wait_busy(1'b1);
    wait_busy(1'b0);
    repeat (2) @(posedge CLOCK);
    check("later ticks", tick_total - t0, 32'd13);
    rd_chk("high locked", 8'h79, {6'h0, res[9:8]});
    rd_chk("low locked", 8'h78, res[7:0]);
    wr(8'h7C, 8'h65);
    rd_chk("high left", 8'h79, res[9:2]);
    rd_chk("low left", 8'h78, {res[1:0], 6'h0});
    rd_chk("high left again", 8'h79, res[9:2]);
    wr(8'h7A, 8'h92);
    rd_chk("flag cleared", 8'h7A, 8'h82);
    // Prescaler codes
    for (int p = 0; p < 8; p++) begin
      wr(8'h7A, {5'h1A, p[2:0]});
      wait_busy(1'b1);
      wait_busy(1'b0);
      repeat (2) @(posedge CLOCK);
      check("divider", tick_gap, (p < 2) ? 32'd2 : (32'd1 << p));
    end
    // Interrupt request gating and clearing
    GLOBAL_IRQ_EN <= 1'b1;
    wr(8'h7A, 8'hDA);
    wait_busy(1'b1);
    wait_busy(1'b0);
    repeat (2) @(posedge CLOCK);
    check("irq on", IRQ_REQ, 32'h1);
    GLOBAL_IRQ_EN <= 1'b0;
    repeat (3) @(posedge CLOCK);
    check("irq gated", IRQ_REQ, 32'h0);
    GLOBAL_IRQ_EN <= 1'b1;
    IRQ_ACK <= 1'b1;
    @(posedge CLOCK);
    IRQ_ACK <= 1'b0;
    repeat (3) @(posedge CLOCK);
    check("irq acked", IRQ_REQ, 32'h0);
    rd_chk("flag acked", 8'h7A, 8'h8A);
    // Auto trigger sources
    wr(8'h7A, 8'hA0);
    for (int s = 1; s < 8; s++) begin
      wr(8'h7B, 8'(s));
      TRIG_FLAGS <= 7'h01 << (s - 1);
      wait_busy(1'b1);
      wait_busy(1'b0);
      TRIG_FLAGS <= 7'h00;
    end
    TRIG_FLAGS <= 7'h04;
    wr(8'h7B, 8'h03);
    wait_busy(1'b1);
    wait_busy(1'b0);
    wr(8'h7B, 8'h00);
    stay_idle(40);
    wr(8'h7A, 8'h80);
    wr(8'h7B, 8'h01);
    TRIG_FLAGS <= 7'h01;
    stay_idle(40);
    // Free running, channel lag, then disable mid-conversion
    TRIG_FLAGS <= 7'h00;
    wr(8'h7B, 8'h00);
    wr(8'h7A, 8'hF8);
    wait_irq();
    check("restarted", {IRQ_REQ, CONV_BUSY}, 32'h3);
    // Written after a completion: the next result still uses the old channel
    wr(8'h7C, 8'h67);
    repeat (2) begin
      check("lag channel", CHANNEL_SELECT, 32'h5);
      wr(8'h7A, 8'hF8);
      wait_irq();
    end
    check("lag applied", CHANNEL_SELECT, 32'h7);
    wr(8'h7A, 8'h00);
    repeat (2) @(posedge CLOCK);
    check("aborted", {CONV_ON, CONV_BUSY}, 32'h0);
    report_and_stop();
  end

  initial begin
    #200000;
    error_cnt++;
    report_and_stop();
  end
endmodule
